// [design/ccra_pkg.sv]
// package: cpu control register layout and arbiter types
package ccra_pkg;
  // ---------------------------------------------------------------
  // register field positions
  // ---------------------------------------------------------------
  localparam int NCR_BIT = 17;
  localparam int LBE_BIT = 16;
  localparam int SPL_LSB = 11;
  localparam int CPL_LSB = 6;
  localparam int COP_LSB = 1;
  localparam int SPE_BIT = 0;
  localparam int FLD_W = 5;
  // ---------------------------------------------------------------
  // reset values, defined bit mask and counter constants
  // ---------------------------------------------------------------
  localparam logic [4:0] SPL_RST = 5'h10;
  localparam logic [4:0] CPL_RST = 5'h10;
  localparam logic [4:0] COP_RST = 5'h08;
  localparam logic [31:0] DEFINED_MASK = 32'h0003_ffff;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [4:0] CNT_ZERO = 5'h00;

  typedef struct packed {
    logic no_compare_reset;
    logic local_bus_enable;
    logic [4:0] slave_pending_limit;
    logic [4:0] core_pending_limit;
    logic [4:0] core_ownership_period;
    logic slave_port_enable;
  } ccra_ctrl_t;

  // requests from the two ram masters
  typedef struct packed {
    logic core;
    logic slave;
  } ccra_req_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CORE  = 2'b01,
    ST_GUARD = 2'b10,
    ST_SLAVE = 2'b11
  } ccra_state_t;
endpackage

// [design/ccra_top.sv]
// cpu control register, ram arbiter, local bus gate and count clear control
// How it works
// R01 - no_compare_reset set keeps count running on compare match; cleared clears it
// R02 - local bus unusable until enabled; local accesses error while disabled
// R03 - slave waiting slave_pending_limit cycles against core takes ram from core
// R04 - core waiting core_pending_limit cycles against slave takes ram from slave
// R05 - core keeps ram core_ownership_period cycles after winning, no arbitration
// R06 - slave_port_enable clear stalls every slave access; reset value one
// R07 - undefined control bits read zero; software writes zero
// R08 - software keeps the application call base pointer word aligned
// R09 - control register reached only by privileged system register moves
// R10 - a requester's pending count restarts when it is granted
module ccra_top (
  input wire logic ref_clk_i,                  // cpu clock
  input wire logic rst_n_i,                    // sync reset, active low
  input wire logic sr_wr_i,                    // privileged move-to pulse
  input wire logic [31:0] sr_wdata_i,          // move-to data
  output logic [31:0] sr_rdata_o,              // move-from data
  input wire ccra_pkg::ccra_req_t req_i,       // ram requests core/slave
  output ccra_pkg::ccra_req_t gnt_o,           // ram grants core/slave
  output logic slave_stall_o,                  // slave access held
  input wire logic local_req_i,                // access to local section
  output logic local_err_o,                    // bus error for local access
  output logic local_gnt_o,                    // local access accepted
  input wire logic cmp_match_i,                // count equals compare
  output logic count_clr_o                     // clear count this cycle
);
  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  ccra_pkg::ccra_ctrl_t ctrl_q, ctrl_d;
  logic [31:0] rdata_d;

  // R09 privileged move only
  always_comb begin
    ctrl_d = ctrl_q;
    if (sr_wr_i) begin
      ctrl_d.no_compare_reset = sr_wdata_i[ccra_pkg::NCR_BIT];
      ctrl_d.local_bus_enable = sr_wdata_i[ccra_pkg::LBE_BIT];
      ctrl_d.slave_pending_limit = sr_wdata_i[ccra_pkg::SPL_LSB +: ccra_pkg::FLD_W];
      ctrl_d.core_pending_limit = sr_wdata_i[ccra_pkg::CPL_LSB +: ccra_pkg::FLD_W];
      ctrl_d.core_ownership_period = sr_wdata_i[ccra_pkg::COP_LSB +: ccra_pkg::FLD_W];
      ctrl_d.slave_port_enable = sr_wdata_i[ccra_pkg::SPE_BIT];
    end
    // R07 undefined bits zero
    rdata_d = {14'h0000, ctrl_d} & ccra_pkg::DEFINED_MASK;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= '{no_compare_reset: 1'b0, local_bus_enable: 1'b0,
                 slave_pending_limit: ccra_pkg::SPL_RST,
                 core_pending_limit: ccra_pkg::CPL_RST,
                 core_ownership_period: ccra_pkg::COP_RST,
                 slave_port_enable: 1'b1};
      sr_rdata_o <= {14'h0000, 1'b0, 1'b0, ccra_pkg::SPL_RST, ccra_pkg::CPL_RST, ccra_pkg::COP_RST, 1'b1};
    end else begin
      ctrl_q <= ctrl_d;
      sr_rdata_o <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // count clear and local bus gate
  // ---------------------------------------------------------------
  logic count_clr_d, local_err_d, local_gnt_d;
  always_comb begin
    // R01 compare match clear
    count_clr_d = cmp_match_i && !ctrl_q.no_compare_reset;
    // R02 local bus gate
    local_err_d = local_req_i && !ctrl_q.local_bus_enable;
    local_gnt_d = local_req_i && ctrl_q.local_bus_enable;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      count_clr_o <= 1'b0;
      local_err_o <= 1'b0;
      local_gnt_o <= 1'b0;
    end else begin
      count_clr_o <= count_clr_d;
      local_err_o <= local_err_d;
      local_gnt_o <= local_gnt_d;
    end
  end

  // ---------------------------------------------------------------
  // ram arbiter
  // ---------------------------------------------------------------
  ccra_pkg::ccra_state_t st_q, st_d;
  logic [4:0] cwait_q, cwait_d, swait_q, swait_d, own_q, own_d;
  logic sreq;
  ccra_pkg::ccra_req_t gnt_d;
  logic stall_d;

  always_comb begin
    // R06 disabled slave never requests
    sreq = req_i.slave && ctrl_q.slave_port_enable;
    st_d = st_q;
    own_d = own_q;
    cwait_d = cwait_q;
    swait_d = swait_q;
    unique case (st_q)
      ccra_pkg::ST_IDLE: begin
        if (req_i.core) begin
          st_d = ccra_pkg::ST_GUARD;
          own_d = ctrl_q.core_ownership_period;
        end else if (sreq) begin
          st_d = ccra_pkg::ST_SLAVE;
        end
      end
      ccra_pkg::ST_GUARD: begin
        // R05 guaranteed ownership, no arbitration
        if (own_q <= ccra_pkg::CNT_ONE) begin
          st_d = ccra_pkg::ST_CORE;
        end else begin
          own_d = own_q - ccra_pkg::CNT_ONE;
        end
      end
      ccra_pkg::ST_CORE: begin
        // R03 slave limit pre-empts core
        if (sreq && (!req_i.core || swait_q >= ctrl_q.slave_pending_limit)) begin
          st_d = ccra_pkg::ST_SLAVE;
        end else if (!req_i.core) begin
          st_d = ccra_pkg::ST_IDLE;
        end
      end
      ccra_pkg::ST_SLAVE: begin
        // R04 core limit pre-empts slave
        if (req_i.core && (!sreq || cwait_q >= ctrl_q.core_pending_limit)) begin
          st_d = ccra_pkg::ST_GUARD;
          own_d = ctrl_q.core_ownership_period;
        end else if (!sreq) begin
          st_d = ccra_pkg::ST_IDLE;
        end
      end
    endcase
    // R10 wait restarts on grant
    if (st_d == ccra_pkg::ST_SLAVE || !sreq) begin
      swait_d = ccra_pkg::CNT_ZERO;
    end else if (swait_q != '1) begin
      swait_d = swait_q + ccra_pkg::CNT_ONE;
    end
    if (st_d == ccra_pkg::ST_CORE || st_d == ccra_pkg::ST_GUARD || !req_i.core) begin
      cwait_d = ccra_pkg::CNT_ZERO;
    end else if (cwait_q != '1) begin
      cwait_d = cwait_q + ccra_pkg::CNT_ONE;
    end
    gnt_d.core = (st_d == ccra_pkg::ST_CORE || st_d == ccra_pkg::ST_GUARD) && req_i.core;
    gnt_d.slave = (st_d == ccra_pkg::ST_SLAVE) && sreq;
    // R06 slave stall whenever the slave request is not granted, so always while disabled
    stall_d = req_i.slave && !gnt_d.slave;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_q <= ccra_pkg::ST_IDLE;
      own_q <= ccra_pkg::CNT_ZERO;
      cwait_q <= ccra_pkg::CNT_ZERO;
      swait_q <= ccra_pkg::CNT_ZERO;
      gnt_o <= '0;
      slave_stall_o <= 1'b0;
    end else begin
      st_q <= st_d;
      own_q <= own_d;
      cwait_q <= cwait_d;
      swait_q <= swait_d;
      gnt_o <= gnt_d;
      slave_stall_o <= stall_d;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // R01 clear follows match
  a_count_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R01
    cmp_match_i |=> count_clr_o == !$past(ctrl_q.no_compare_reset))
    else $error("count clear wrong");
  // R01 no clear without match
  a_clear_needs_match: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R01
    !cmp_match_i |=> !count_clr_o)
    else $error("count cleared without match");
  // R02 disabled local bus
  a_local_error: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R02
    local_req_i && !ctrl_q.local_bus_enable |=> local_err_o && !local_gnt_o)
    else $error("local access not errored");
  // R02 enabled local bus
  a_local_grant: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R02
    local_req_i && ctrl_q.local_bus_enable |=> local_gnt_o && !local_err_o)
    else $error("enabled local access refused");
  // R03 slave pre-emption
  a_slave_limit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R03
    st_q == ccra_pkg::ST_CORE && sreq && swait_q >= ctrl_q.slave_pending_limit |=> gnt_o.slave)
    else $error("slave limit ignored");
  // R04 core pre-emption
  a_core_limit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R04
    st_q == ccra_pkg::ST_SLAVE && req_i.core && cwait_q >= ctrl_q.core_pending_limit |=> gnt_o.core)
    else $error("core limit ignored");
  // R03 R04 one ram owner
  a_single_owner: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R03
    !(gnt_o.core && gnt_o.slave))
    else $error("two ram owners");
  // R05 guard period held
  a_guard_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R05
    st_q == ccra_pkg::ST_GUARD && own_q > ccra_pkg::CNT_ONE |=> st_q == ccra_pkg::ST_GUARD)
    else $error("ownership period broken");
  // R05 core served in guard
  a_guard_grant: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R05
    st_q == ccra_pkg::ST_GUARD && req_i.core |=> gnt_o.core && !gnt_o.slave)
    else $error("core not served in guard");
  // R06 disabled slave stalls
  a_slave_stall: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R06
    req_i.slave && !ctrl_q.slave_port_enable |=> slave_stall_o && !gnt_o.slave)
    else $error("disabled slave not stalled");
  // R07 undefined bits zero
  a_read_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R07
    (sr_rdata_o & ~ccra_pkg::DEFINED_MASK) == 32'h0000_0000)
    else $error("undefined bits nonzero");
  // R09 move-to readback
  a_write_readback: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R09
    sr_wr_i |=> sr_rdata_o == ($past(sr_wdata_i) & ccra_pkg::DEFINED_MASK))
    else $error("written value not read back");
  // R10 slave wait restart
  a_wait_restart: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R10
    st_q == ccra_pkg::ST_SLAVE |-> swait_q == ccra_pkg::CNT_ZERO)
    else $error("slave wait not restarted");
endmodule

// [verification/ccra_slave_model.sv]
// slave bus master model that requests the ram and holds it
module ccra_slave_model (
  input wire logic ref_clk_i, // cpu clock
  input wire logic rst_n_i,   // sync reset
  input wire logic start_i,   // begin one access
  input wire logic gnt_i,     // ram grant to slave
  output logic req_o          // ram request
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] held_q;
  // request held until granted, then for 32 granted cycles
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || (req_o && gnt_i && held_q == 6'h1f)) begin
      req_o <= 1'b0;
      held_q <= 6'h00;
    end else if (start_i) begin
      req_o <= 1'b1;
    end else if (req_o && gnt_i) begin
      held_q <= held_q + 6'h01;
    end
  end
endmodule

// [verification/cpu_control_ram_arbitration_bench.sv]
// self-checking bench for the cpu control register and ram arbiter
module cpu_control_ram_arbitration_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sr_wr_i = 1'b0;
  logic [31:0] sr_wdata_i = 32'h0;
  logic [31:0] sr_rdata_o;
  ccra_pkg::ccra_req_t req_i;
  ccra_pkg::ccra_req_t gnt_o;
  logic slave_stall_o, local_err_o, local_gnt_o, count_clr_o, slv_req;
  logic local_req_i = 1'b0;
  logic cmp_match_i = 1'b0;
  logic core_req = 1'b0;
  logic start = 1'b0;
  int error_cnt = 0;
  int checks_done = 0;
  int n;
  always #4 ref_clk_i = ~ref_clk_i;
  assign req_i = '{core: core_req, slave: slv_req};
  ccra_top dut (.ref_clk_i, .rst_n_i, .sr_wr_i, .sr_wdata_i, .sr_rdata_o, .req_i, .gnt_o, .slave_stall_o,
    .local_req_i, .local_err_o, .local_gnt_o, .cmp_match_i, .count_clr_o);
  ccra_slave_model model (.ref_clk_i, .rst_n_i, .start_i(start), .gnt_i(gnt_o.slave), .req_o(slv_req));
  // ---------------------------------------------------------------
  // access and compare tasks
  // ---------------------------------------------------------------
  task automatic fail(input string m);
    error_cnt++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) fail(m);
  endtask
  task automatic chk1(input logic got, input logic exp, input string m);
    checks_done++;
    if (got !== exp) fail(m);
  endtask
  task automatic chk_rng(input int k, input int lo, input int hi, input string m);
    checks_done++;
    if (k < lo || k > hi) fail(m);
  endtask
  task automatic wr(input logic [31:0] d);
    @(negedge ref_clk_i);
    sr_wr_i = 1'b1;
    sr_wdata_i = d;
    @(negedge ref_clk_i);
    sr_wr_i = 1'b0;
    @(negedge ref_clk_i);
  endtask
  task automatic poke(input bit cmp);
    @(negedge ref_clk_i);
    cmp_match_i = cmp;
    local_req_i = !cmp;
    @(negedge ref_clk_i);
    cmp_match_i = 1'b0;
    local_req_i = 1'b0;
  endtask
  task automatic wgnt(input bit s, output int k);
    k = 0;
    while ((s ? gnt_o.slave : gnt_o.core) !== 1'b1) begin
      @(negedge ref_clk_i);
      k++;
      if (k > 80) begin
        fail("grant wait");
        tally_and_finish();
      end
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    chk(sr_rdata_o, 32'h0000_8411, "reset value");
    chk1(gnt_o.core | gnt_o.slave, 1'b0, "reset grant");
    poke(1'b0);
    chk1(local_err_o & ~local_gnt_o, 1'b1, "local disabled");
    poke(1'b1);
    chk1(count_clr_o, 1'b1, "clear on match");
    wr(32'hffff_ffff);
    chk(sr_rdata_o, 32'h0003_ffff, "undefined bits");
    // ncr lbe set, spl 2, cpl 3, cop 4, spe set
    wr(32'h0003_10c9);
    chk(sr_rdata_o, 32'h0003_10c9, "config");
    poke(1'b0);
    chk1(local_gnt_o & ~local_err_o, 1'b1, "local enabled");
    poke(1'b1);
    chk1(count_clr_o, 1'b0, "no clear");
    $display("test registers done");
    core_req = 1'b1;
    start = 1'b1;
    @(negedge ref_clk_i);
    start = 1'b0;
    wgnt(1'b0, n);
    wgnt(1'b1, n);
    chk_rng(n, 4, 9, "guard then slave");
    chk1(gnt_o.core, 1'b0, "one owner");
    wgnt(1'b0, n);
    chk_rng(n, 2, 7, "core preempts");
    core_req = 1'b0;
    for (n = 0; n < 80 && slv_req; n++) @(negedge ref_clk_i);
    chk1(slv_req, 1'b0, "slave done");
    $display("test arbitration done");
    wr(32'h0003_10c8);
    start = 1'b1;
    @(negedge ref_clk_i);
    start = 1'b0;
    repeat (8) @(negedge ref_clk_i);
    chk1(slave_stall_o & ~gnt_o.slave, 1'b1, "disabled stalls");
    wr(32'h0003_10c9);
    wgnt(1'b1, n);
    chk_rng(n, 0, 4, "enabled proceeds");
    $display("test slave enable done");
    tally_and_finish();
  end
endmodule
